/* rtl/scmc_top.sv */
// system clock mode control: ahb registers and clock selection
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module scmc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        clock_source_pin,
  input  wire logic        external_clock_input,
  input  wire logic        rtc_clock_input,
  input  wire logic        pll_output_clock,
  output logic             pll_reference_clock,
  output logic             system_clock_out,
  output logic             pll_power_down,
  output logic             pll_counter_clear_control,
  output logic             ref_divider_bypass,
  output logic             output_divider_enable,
  output logic      [12:0] pll_mult_factor,
  output logic      [12:0] pll_ref_div_value,
  output logic      [8:0]  pll_out_div_value,
  output logic      [15:0] pll_init_value
);
  // ************************************************************
  // declarations
  // ************************************************************
  logic [15:0] gen_one_r;
  logic [15:0] gen_one_nxt;
  logic [15:0] gen_two_r;
  logic [15:0] gen_two_nxt;
  logic [15:0] gen_three_r;
  logic [15:0] gen_three_nxt;
  logic [15:0] gen_four_r;
  logic [15:0] gen_four_nxt;
  logic        sel_r;
  logic        sel_nxt;
  logic [12:0] mult_r;
  logic [12:0] mult_nxt;
  logic [12:0] rdiv_r;
  logic [12:0] rdiv_nxt;
  logic [8:0]  odiv_r;
  logic [8:0]  odiv_nxt;
  logic        dp_wr_r;
  logic        dp_wr_nxt;
  logic [13:0] dp_idx_r;
  logic [13:0] dp_idx_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        first_r;
  logic        addr_ok;
  logic [15:0] cfg_two_view;
  logic [2:0]  pin_state;
  logic        pll_on;
  logic        byp_on;

  // ************************************************************
  // helpers
  // ************************************************************
  // anything outside the low word map resolves to no register
  function automatic logic [13:0] idx_of(input logic [31:0] a);
    if (a[31:16] == 16'h0000 && a[1:0] == 2'h0)
      return a[15:2];
    else
      return scmc_pkg::IDX_NONE;
  endfunction : idx_of

  function automatic logic [31:0] rd_word(
    input logic [13:0] idx,
    input logic [15:0] g1,
    input logic [15:0] g2,
    input logic [15:0] g3,
    input logic [15:0] g4,
    input logic [15:0] c2
  );
    logic [15:0] v;
    v = 16'h0000;
    if (idx == scmc_pkg::IDX_GEN_ONE)
      v = g1;
    else if (idx == scmc_pkg::IDX_GEN_TWO)
      v = g2;
    else if (idx == scmc_pkg::IDX_GEN_THREE)
      v = g3;
    else if (idx == scmc_pkg::IDX_GEN_FOUR)
      v = g4;
    else if (idx == scmc_pkg::IDX_CLK_CFG_TWO)
      v = c2;
    return {16'h0000, v};
  endfunction : rd_word

  // ************************************************************
  // strap and switch state into hclk
  // ************************************************************
  scmc_sync #(.WIDTH(3), .RST(3'h4)) u_pin_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({byp_on, pll_on, clock_source_pin}),
    .q     (pin_state)
  );

  // strap is tied statically, so a plain mux is safe here
  assign pll_reference_clock = clock_source_pin ?
                               external_clock_input :
                               rtc_clock_input;

  scmc_clk_switch u_switch (
    .rst_n   (hresetn),
    .sel_pll (sel_r),
    .byp_clk (pll_reference_clock),
    .pll_clk (pll_output_clock),
    .clk_out (system_clock_out),
    .pll_on  (pll_on),
    .byp_on  (byp_on)
  );

  // status shows select, strap and which path drives the clock, never lock
  always_comb
  begin
    cfg_two_view = 16'h0000;
    cfg_two_view[scmc_pkg::SEL_BIT]      = sel_nxt;
    cfg_two_view[scmc_pkg::PIN_STAT_BIT] = pin_state[0];
    cfg_two_view[scmc_pkg::PLL_ACT_BIT]  = pin_state[1];
    cfg_two_view[scmc_pkg::BYP_ACT_BIT]  = pin_state[2];
  end

  // ************************************************************
  // ahb-lite slave, zero wait states
  // ************************************************************
  assign addr_ok = hsel & hready & htrans[1];

  always_comb
  begin
    gen_one_nxt   = gen_one_r;
    gen_two_nxt   = gen_two_r;
    gen_three_nxt = gen_three_r;
    gen_four_nxt  = gen_four_r;
    sel_nxt       = sel_r;
    dp_wr_nxt     = 1'b0;
    dp_idx_nxt    = dp_idx_r;
    hrdata_nxt    = hrdata_r;
    if (dp_wr_r)
    begin
      if (dp_idx_r == scmc_pkg::IDX_GEN_ONE)
        gen_one_nxt = hwdata[15:0];
      if (dp_idx_r == scmc_pkg::IDX_GEN_TWO)
        gen_two_nxt = hwdata[15:0] & scmc_pkg::GEN_TWO_MASK;
      if (dp_idx_r == scmc_pkg::IDX_GEN_THREE)
        gen_three_nxt = hwdata[15:0];
      if (dp_idx_r == scmc_pkg::IDX_GEN_FOUR)
        gen_four_nxt = hwdata[15:0] & scmc_pkg::GEN_FOUR_MASK;
      // select is the only field here that touches the switch
      if (dp_idx_r == scmc_pkg::IDX_CLK_CFG_TWO)
        sel_nxt = hwdata[scmc_pkg::SEL_BIT];
    end
    if (addr_ok)
    begin
      dp_wr_nxt  = hwrite;
      dp_idx_nxt = idx_of(haddr);
      // read sees a write still in its data phase
      if (!hwrite)
        hrdata_nxt = rd_word(idx_of(haddr), gen_one_nxt, gen_two_nxt,
                             gen_three_nxt, gen_four_nxt,
                             cfg_two_view);
    end
    mult_nxt = {1'b0, gen_one_nxt[scmc_pkg::RATIO_MSB:0]}
               + scmc_pkg::MULT_ADD;
    if (gen_two_nxt[scmc_pkg::RDBYP_BIT])
      rdiv_nxt = scmc_pkg::RDIV_BYP;
    else
      rdiv_nxt = {1'b0, gen_two_nxt[scmc_pkg::RATIO_MSB:0]}
                 + scmc_pkg::RDIV_ADD;
    if (gen_four_nxt[scmc_pkg::ODEN_BIT])
      odiv_nxt = {1'b0, gen_four_nxt[scmc_pkg::ODR_MSB:0]}
                 + scmc_pkg::ODIV_ADD;
    else
      odiv_nxt = scmc_pkg::ODIV_OFF;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gen_one_r   <= scmc_pkg::GEN_ONE_RST;
      gen_two_r   <= scmc_pkg::GEN_TWO_RST;
      gen_three_r <= scmc_pkg::GEN_THREE_RST;
      gen_four_r  <= scmc_pkg::GEN_FOUR_RST;
      sel_r       <= 1'b0;
      mult_r      <= scmc_pkg::MULT_ADD;
      rdiv_r      <= scmc_pkg::RDIV_ADD;
      odiv_r      <= scmc_pkg::ODIV_OFF;
      dp_wr_r     <= 1'b0;
      dp_idx_r    <= scmc_pkg::IDX_NONE;
      hrdata_r    <= 32'h0000_0000;
      first_r     <= 1'b1;
    end
    else
    begin
      gen_one_r   <= gen_one_nxt;
      gen_two_r   <= gen_two_nxt;
      gen_three_r <= gen_three_nxt;
      gen_four_r  <= gen_four_nxt;
      sel_r       <= sel_nxt;
      mult_r      <= mult_nxt;
      rdiv_r      <= rdiv_nxt;
      odiv_r      <= odiv_nxt;
      dp_wr_r     <= dp_wr_nxt;
      dp_idx_r    <= dp_idx_nxt;
      hrdata_r    <= hrdata_nxt;
      first_r     <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = scmc_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_r;
  // the analog pll itself sits outside and locks within 4 ms
  assign pll_power_down  = gen_one_r[scmc_pkg::PWRDN_BIT];
  assign pll_counter_clear_control = gen_one_r[scmc_pkg::CNT_CLR_BIT];
  assign ref_divider_bypass    = gen_two_r[scmc_pkg::RDBYP_BIT];
  assign output_divider_enable = gen_four_r[scmc_pkg::ODEN_BIT];
  assign pll_mult_factor   = mult_r;
  assign pll_ref_div_value = rdiv_r;
  assign pll_out_div_value = odiv_r;
  assign pll_init_value    = gen_three_r;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence wr_s(logic [13:0] idx);
    addr_ok && hwrite && idx_of(haddr) == idx;
  endsequence

  sequence rd_s(logic [13:0] idx);
    addr_ok && !hwrite && idx_of(haddr) == idx;
  endsequence

  sequence sel_zero_s;
    wr_s(scmc_pkg::IDX_CLK_CFG_TWO) ##1 !hwdata[scmc_pkg::SEL_BIT];
  endsequence

  bypass_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sel_zero_s |=> !sel_r
    && (hrdata == $past(hrdata) || $past(addr_ok && !hwrite)))
    else $error("select write of zero did not give bypass");

  power_kept_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_s(scmc_pkg::IDX_CLK_CFG_TWO) ##1 1'b1
    |=> pll_power_down == $past(pll_power_down))
    else $error("select write changed pll power");

  strap_status_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_s(scmc_pkg::IDX_CLK_CFG_TWO)
    |=> hrdata[scmc_pkg::PIN_STAT_BIT] == $past(pin_state[0]))
    else $error("strap status bit wrong");

  mult_plus_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_s(scmc_pkg::IDX_GEN_ONE) ##1 1'b1
    |=> pll_mult_factor == {1'b0, $past(hwdata[11:0])} + 13'h0004)
    else $error("multiplication factor not field plus four");

  ref_div_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_s(scmc_pkg::IDX_GEN_TWO) ##1 !hwdata[scmc_pkg::RDBYP_BIT]
    |=> pll_ref_div_value == {1'b0, $past(hwdata[11:0])} + 13'h0004)
    else $error("reference divider value wrong");

  out_div_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_s(scmc_pkg::IDX_GEN_FOUR) ##1 hwdata[scmc_pkg::ODEN_BIT]
    |=> pll_out_div_value == {1'b0, $past(hwdata[7:0])} + 9'h001)
    else $error("output divider value wrong");

  reset_state_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    first_r |-> pll_power_down && !sel_r
               && pll_init_value == 16'h0806)
    else $error("reset did not power down or select bypass");

  unmapped_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_s(scmc_pkg::IDX_NONE) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : scmc_top
`default_nettype wire

/* rtl/scmc_pkg.sv */
// constants for the system clock mode control block
package scmc_pkg;
  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam int          IDX_W          = 14;
  localparam logic [13:0] IDX_GEN_ONE    = 14'h1c20;
  localparam logic [13:0] IDX_GEN_TWO    = 14'h1c21;
  localparam logic [13:0] IDX_GEN_THREE  = 14'h1c22;
  localparam logic [13:0] IDX_GEN_FOUR   = 14'h1c23;
  localparam logic [13:0] IDX_CLK_CFG_TWO = 14'h1c1f;
  localparam logic [13:0] IDX_NONE       = 14'h0000;

  // ************************************************************
  // reset values and writable masks
  // ************************************************************
  localparam logic [15:0] GEN_ONE_RST    = 16'h1000;
  localparam logic [15:0] GEN_TWO_RST    = 16'h0000;
  localparam logic [15:0] GEN_TWO_MASK   = 16'h8fff;
  localparam logic [15:0] GEN_THREE_RST  = 16'h0806;
  localparam logic [15:0] GEN_FOUR_RST   = 16'h0000;
  localparam logic [15:0] GEN_FOUR_MASK  = 16'h02ff;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PWRDN_BIT    = 12;
  localparam int CNT_CLR_BIT  = 15;
  localparam int RATIO_MSB    = 11;
  localparam int RDBYP_BIT    = 15;
  localparam int ODEN_BIT     = 9;
  localparam int ODR_MSB      = 7;
  localparam int SEL_BIT      = 0;
  localparam int PIN_STAT_BIT = 1;
  localparam int PLL_ACT_BIT  = 2;
  localparam int BYP_ACT_BIT  = 3;

  // ************************************************************
  // factor offsets and bus codes
  // ************************************************************
  localparam logic [12:0] MULT_ADD   = 13'h0004;
  localparam logic [12:0] RDIV_ADD   = 13'h0004;
  localparam logic [12:0] RDIV_BYP   = 13'h0001;
  localparam logic [8:0]  ODIV_ADD   = 9'h001;
  localparam logic [8:0]  ODIV_OFF   = 9'h001;
  localparam logic        HRESP_OKAY = 1'b0;
endpackage : scmc_pkg

/* rtl/scmc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module scmc_sync #(
  parameter int         WIDTH = 1,
  parameter logic [2:0] RST   = 3'h0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // ************************************************************
  // meta_r is read by q_r only
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RST[WIDTH-1:0];
      q_r    <= RST[WIDTH-1:0];
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule : scmc_sync
`default_nettype wire

/* rtl/scmc_clk_switch.sv */
// glitch-free switch between bypass source and pll output
`timescale 1ns/100ps
`default_nettype none
module scmc_clk_switch (
  input  wire logic rst_n,
  input  wire logic sel_pll,
  input  wire logic byp_clk,
  input  wire logic pll_clk,
  output logic      clk_out,
  output logic      pll_on,
  output logic      byp_on
);
  logic       pll_en_r;
  logic       byp_en_r;
  logic       pll_req;
  logic       byp_req;

  // ************************************************************
  // request synchronisers, one per clock
  // ************************************************************
  // each side only asks once the other side has let go
  scmc_sync #(.WIDTH(1), .RST(3'h0)) u_pll_req (
    .clk   (pll_clk),
    .rst_n (rst_n),
    .d     (sel_pll & ~byp_en_r),
    .q     (pll_req)
  );
  scmc_sync #(.WIDTH(1), .RST(3'h1)) u_byp_req (
    .clk   (byp_clk),
    .rst_n (rst_n),
    .d     (~sel_pll & ~pll_en_r),
    .q     (byp_req)
  );

  // ************************************************************
  // enables change on each clock's low phase
  // ************************************************************
  always_ff @(negedge pll_clk or negedge rst_n)
  begin
    if (!rst_n)
      pll_en_r <= 1'b0;
    else
      pll_en_r <= pll_req;
  end

  always_ff @(negedge byp_clk or negedge rst_n)
  begin
    if (!rst_n)
      byp_en_r <= 1'b1;
    else
      byp_en_r <= byp_req;
  end

  // gating while low keeps every pulse whole
  assign clk_out = (pll_clk & pll_en_r) | (byp_clk & byp_en_r);
  assign pll_on  = pll_en_r;
  assign byp_on  = byp_en_r;

  excl_enable_a: assert property (
    @(posedge pll_clk) disable iff (!rst_n) !(pll_en_r && byp_en_r))
    else $error("both clock paths enabled");
endmodule : scmc_clk_switch
`default_nettype wire

/* sim/tb_system_clock_mode_control.sv */
// self-checking bench for the system clock mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_system_clock_mode_control;
  // ************************************************************
  // signals and clocks
  // ************************************************************
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin;
  logic        ext_clk;
  logic        rtc_clk;
  logic        pll_clk;
  logic        ref_clk;
  logic        sys_clk;
  logic        pwrdn;
  logic        cnt_clr;
  logic        rd_byp;
  logic        od_en;
  logic [12:0] mult;
  logic [12:0] rdiv;
  logic [8:0]  odiv;
  logic [15:0] init_v;
  int          fails;
  int          samples_checked;
  realtime     last_edge;
  realtime     min_pulse;

  scmc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .clock_source_pin(pin), .external_clock_input(ext_clk),
    .rtc_clock_input(rtc_clk), .pll_output_clock(pll_clk),
    .pll_reference_clock(ref_clk), .system_clock_out(sys_clk),
    .pll_power_down(pwrdn), .pll_counter_clear_control(cnt_clr),
    .ref_divider_bypass(rd_byp), .output_divider_enable(od_en),
    .pll_mult_factor(mult), .pll_ref_div_value(rdiv),
    .pll_out_div_value(odiv), .pll_init_value(init_v));

  always #20 hclk = ~hclk;
  always #41 ext_clk = ~ext_clk;
  always #15259 rtc_clk = ~rtc_clk;
  // analog pll gives no output while powered down
  always #5 pll_clk = (pwrdn === 1'b0) ? ~pll_clk : 1'b0;

  // narrowest pulse seen on the switched clock
  always @(sys_clk)
  begin
    if (hresetn === 1'b1 && $realtime - last_edge < min_pulse)
      min_pulse = $realtime - last_edge;
    last_edge = $realtime;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // ready is constant high today, but no count is assumed
  task wait_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_ready

  task wr(input logic [13:0] idx, input logic [15:0] d);
    haddr  <= {16'h0000, idx, 2'b00};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_ready();
    // outputs land on the data edge; look one edge later
    @(posedge hclk);
  endtask : wr

  task rd(input logic [13:0] idx, output logic [31:0] d);
    haddr  <= {16'h0000, idx, 2'b00};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask : rd

  task rchk(input string n, input logic [13:0] idx, input logic [15:0] e);
    logic [31:0] d;
    rd(idx, d);
    chk(n, {16'h0000, e}, d);
  endtask : rchk

  // status bits lag the switch by the old and new clock edges
  task poll_cfg(input int b);
    logic [31:0] d;
    int          k;
    k = 0;
    do
    begin
      rd(scmc_pkg::IDX_CLK_CFG_TWO, d);
      k++;
    end
    while (d[b] !== 1'b1 && k < 4000);
    if (k >= 4000)
    begin
      fails++;
      stop_test();
    end
  endtask : poll_cfg

  // 0 external, 1 pll, 2 rtc; sampled clear of the source edge
  task follow(input int w, input string n);
    logic s;
    repeat (6)
    begin
      case (w)
        0: @(ext_clk);
        1: @(pll_clk);
        default: @(rtc_clk);
      endcase
      #2;
      s = (w == 0) ? ext_clk : (w == 1) ? pll_clk : rtc_clk;
      chk(n, {31'h0, s}, {31'h0, sys_clk});
    end
    @(posedge hclk);
  endtask : follow

  task do_reset(input logic p);
    @(posedge hclk);
    hresetn <= 1'b0;
    pin     <= p;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset_values;
    chk("pwrdn", 32'h1, {31'h0, pwrdn});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("mult", 32'h4, {19'h0, mult});
    chk("rdiv", 32'h4, {19'h0, rdiv});
    chk("odiv", 32'h1, {23'h0, odiv});
    chk("init", 32'h0806, {16'h0, init_v});
    rchk("gen_one", scmc_pkg::IDX_GEN_ONE, 16'h1000);
    rchk("gen_two", scmc_pkg::IDX_GEN_TWO, 16'h0000);
    rchk("gen_three", scmc_pkg::IDX_GEN_THREE, 16'h0806);
    rchk("gen_four", scmc_pkg::IDX_GEN_FOUR, 16'h0000);
    rchk("cfg_two", scmc_pkg::IDX_CLK_CFG_TWO, 16'h000a);
    wr(scmc_pkg::IDX_NONE, 16'hffff);
    rchk("unmapped", scmc_pkg::IDX_NONE, 16'h0000);
    rchk("gen_one_kept", scmc_pkg::IDX_GEN_ONE, 16'h1000);
  endtask : t_reset_values

  task t_fields;
    wr(scmc_pkg::IDX_GEN_TWO, 16'hffff);
    rchk("gen_two_mask", scmc_pkg::IDX_GEN_TWO, 16'h8fff);
    chk("rdbyp_div", 32'h1, {19'h0, rdiv});
    chk("rdbyp", 32'h1, {31'h0, rd_byp});
    wr(scmc_pkg::IDX_GEN_TWO, 16'h0005);
    chk("rdiv_5", 32'h9, {19'h0, rdiv});
    wr(scmc_pkg::IDX_GEN_FOUR, 16'hffff);
    rchk("gen_four_mask", scmc_pkg::IDX_GEN_FOUR, 16'h02ff);
    chk("odiv_max", 32'h100, {23'h0, odiv});
    wr(scmc_pkg::IDX_GEN_FOUR, 16'h0002);
    chk("odiv_off", 32'h1, {23'h0, odiv});
    wr(scmc_pkg::IDX_GEN_ONE, 16'h1fff);
    chk("mult_max", 32'h1003, {19'h0, mult});
  endtask : t_fields

  task t_pll_switch;
    wr(scmc_pkg::IDX_CLK_CFG_TWO, 16'h0000);
    wr(scmc_pkg::IDX_GEN_ONE, 16'h118c);
    wr(scmc_pkg::IDX_GEN_TWO, 16'h004c);
    chk("rdiv_50", 32'h50, {19'h0, rdiv});
    wr(scmc_pkg::IDX_GEN_FOUR, 16'h0202);
    chk("odiv_3", 32'h3, {23'h0, odiv});
    chk("oden", 32'h1, {31'h0, od_en});
    wr(scmc_pkg::IDX_GEN_THREE, 16'h0806);
    wr(scmc_pkg::IDX_GEN_ONE, 16'h818c);
    chk("mult_18c", 32'h190, {19'h0, mult});
    chk("cnt_clr", 32'h1, {31'h0, cnt_clr});
    chk("pwr_up", 32'h0, {31'h0, pwrdn});
    follow(0, "byp_pll_up");
    // lock wait shortened: the stand-in pll runs at once
    wr(scmc_pkg::IDX_CLK_CFG_TWO, 16'h0001);
    poll_cfg(scmc_pkg::PLL_ACT_BIT);
    rchk("cfg_pll", scmc_pkg::IDX_CLK_CFG_TWO, 16'h0007);
    follow(1, "pll_path");
    wr(scmc_pkg::IDX_CLK_CFG_TWO, 16'h0000);
    chk("pwr_kept", 32'h0, {31'h0, pwrdn});
    poll_cfg(scmc_pkg::BYP_ACT_BIT);
    rchk("cfg_byp", scmc_pkg::IDX_CLK_CFG_TWO, 16'h000a);
    follow(0, "back_byp");
    wr(scmc_pkg::IDX_GEN_ONE, 16'h918c);
    chk("pwr_down", 32'h1, {31'h0, pwrdn});
  endtask : t_pll_switch

  task t_strap_rtc;
    do_reset(1'b0);
    rchk("gen_one_rst", scmc_pkg::IDX_GEN_ONE, 16'h1000);
    poll_cfg(scmc_pkg::BYP_ACT_BIT);
    rchk("cfg_rtc", scmc_pkg::IDX_CLK_CFG_TWO, 16'h0008);
    wr(scmc_pkg::IDX_GEN_TWO, 16'h8000);
    chk("rtc_rdbyp", 32'h1, {19'h0, rdiv});
    follow(2, "rtc_path");
    chk("ref_rtc", {31'h0, rtc_clk}, {31'h0, ref_clk});
    do_reset(1'b1);
  endtask : t_strap_rtc

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin = 1'b1;
    ext_clk = 1'b0;
    rtc_clk = 1'b0;
    pll_clk = 1'b0;
    fails = 0;
    samples_checked = 0;
    last_edge = 0.0;
    min_pulse = 1.0e9;
    do_reset(1'b1);
    t_reset_values();
    t_fields();
    t_pll_switch();
    t_strap_rtc();
    chk("no_runt", 32'h1, {31'h0, min_pulse >= 4.9});
    stop_test();
  end

  initial
  begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule : tb_system_clock_mode_control
`default_nettype wire
